// file: pbt_target.sv
// Purpose: target side of a 32-bit conventional parallel expansion bus
// Assumes: bus_clk from host, core_clk 250 MHz unrelated; user answers one request at a time
// Notes: single data phase per access; bursts are disconnected with stop
`include "pbt_defs.svh"

module pbt_target (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic bus_clk,
	input wire logic bus_rst,
	// bus pins
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic [31:0] ad_in,
	output logic [31:0] ad_out,
	output logic ad_oe,
	input wire logic [3:0] cbe_in,
	output logic [1:0] cbe_hi_out,
	output logic [1:0] cbe_hi_oe,
	input wire logic cfg_sel_in,
	output logic cfg_sel_out,
	output logic cfg_sel_oe,
	input wire logic par_in,
	output logic par_out,
	output logic par_oe,
	output logic devsel_n_out,
	output logic devsel_oe,
	output logic trdy_n_out,
	output logic trdy_oe,
	output logic stop_n_out,
	output logic stop_oe,
	output logic interrupt_request_out_n,
	output logic irq_oe,
	// core side
	input wire logic bus_enable,
	input wire logic lane_hi_enable,
	input wire logic [2:0] gpio_out,
	input wire logic [2:0] gpio_oe,
	output logic [2:0] gpio_in,
	input wire logic irq_req,
	input wire logic [7:0] mem_base,
	output logic req_valid,
	output logic req_write,
	output logic req_cfg,
	output logic [29:0] req_addr,
	output logic [31:0] req_wdata,
	output logic [3:0] req_be,
	input wire logic rsp_valid,
	input wire logic [31:0] rsp_rdata,
	output logic par_err
);
	import pbt_pkg::*;

	// ------------------------------------------------------------
	// bus clock domain
	// ------------------------------------------------------------
	pbt_state_t st_q;
	pbt_kind_t kind_q;
	logic wr_q;
	logic frame_q;
	logic [29:0] addr_q;
	logic [31:0] wdata_q;
	logic [3:0] be_q;
	logic [31:0] rdata_q;
	logic req_tgl_q;
	logic ack_tgl_sync;
	logic ack_seen_q;
	// last request whose access has ended, answered or not; a toggle differing from it is outstanding
	logic ack_prev_q;
	// read word from the core side, stable once its acknowledge toggles back
	logic [31:0] rdata_core_q;
	// byte enables with unused upper lanes forced off
	logic [3:0] be_lane;
	logic par_pend_q;
	logic par_chk_q;
	logic [35:0] chk_bits_q;
	logic bus_en_sync;
	logic lane_en_sync;
	logic [1:0] en_raw;
	logic [1:0] en_sync;
	logic hit_mem;
	logic hit_cfg;
	logic [3:0] cmd;
	logic data_done;

	assign en_raw = {lane_hi_enable, bus_enable};

	pbt_sync #(.WIDTH(2)) u_en_sync (
		.clk(bus_clk),
		.rst(bus_rst),
		.din(en_raw),
		.dout(en_sync)
	);
	assign bus_en_sync = en_sync[0];
	assign lane_en_sync = en_sync[1];

	// upper lanes on io pins carry no enables, so those bytes never move
	assign be_lane = {lane_en_sync ? cbe_in[3:2] : 2'b11, cbe_in[1:0]};

	assign cmd = cbe_in;
	// address phase: frame falls, command on the lanes
	assign hit_cfg = cfg_sel_in && (cmd == `PBT_CMD_CFG_RD || cmd == `PBT_CMD_CFG_WR);
	assign hit_mem = (cmd == `PBT_CMD_MEM_RD || cmd == `PBT_CMD_MEM_WR)
		&& ad_in[31:24] == mem_base;
	// both ready low ends a data phase
	assign data_done = (st_q == PBT_DATA) && !irdy_n && ack_seen_q;

	always_ff @(posedge bus_clk) begin
		if (bus_rst) begin
			frame_q <= 1'b1;
		end else begin
			frame_q <= frame_n;
		end
	end

	always_ff @(posedge bus_clk) begin
		if (bus_rst) begin
			st_q <= PBT_IDLE;
			kind_q <= PBT_KIND_NONE;
			wr_q <= 1'b0;
			addr_q <= '0;
			be_q <= '0;
			wdata_q <= '0;
		end else begin
			case (st_q)
			PBT_IDLE: begin
				// start of access is frame seen falling; frame held by host
				if (bus_en_sync && frame_q && !frame_n) begin
					if (hit_cfg || hit_mem) begin
						st_q <= PBT_CLAIM;
						kind_q <= hit_cfg ? PBT_KIND_CFG : PBT_KIND_MEM;
						wr_q <= cmd[0];
						addr_q <= ad_in[31:2];
					end else begin
						st_q <= PBT_BUSY;
					end
				end
			end
			PBT_CLAIM: begin
				be_q <= be_lane;
				if (wr_q) begin
					wdata_q <= ad_in;
				end
				st_q <= PBT_DATA;
			end
			PBT_DATA: begin
				if (wr_q && !irdy_n) begin
					wdata_q <= ad_in;
					be_q <= be_lane;
				end
				if (data_done) begin
					st_q <= PBT_TURN;
				end else if (frame_n && irdy_n) begin
					st_q <= PBT_TURN;
				end
			end
			PBT_TURN: begin
				st_q <= PBT_IDLE;
				kind_q <= PBT_KIND_NONE;
			end
			PBT_BUSY: begin
				// ignore someone else's access until the bus goes idle
				if (frame_n && irdy_n) begin
					st_q <= PBT_IDLE;
				end
			end
			default: begin
				st_q <= PBT_IDLE;
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// crossing to the core: toggle out, toggle back
	// ------------------------------------------------------------
	// only one toggle per access: a second one at the answer edge would
	// start a phantom request and hide the answer
	always_ff @(posedge bus_clk) begin
		if (bus_rst) begin
			req_tgl_q <= 1'b0;
		end else if (st_q == PBT_DATA && !ack_seen_q && !irdy_n
			&& ack_tgl_sync == req_tgl_q && req_tgl_q == ack_prev_q) begin
			req_tgl_q <= ~req_tgl_q;
		end
	end

	// answer latch; write data is sent only once irdy shows it valid
	always_ff @(posedge bus_clk) begin
		if (bus_rst) begin
			ack_seen_q <= 1'b0;
		end else if (st_q != PBT_DATA) begin
			ack_seen_q <= 1'b0;
		end else if (!irdy_n && ack_tgl_sync == req_tgl_q && req_tgl_q != ack_prev_q) begin
			ack_seen_q <= 1'b1;
		end
	end

	// an access cut short leaves its request outstanding until the core answers
	always_ff @(posedge bus_clk) begin
		if (bus_rst) begin
			ack_prev_q <= 1'b0;
		end else if (st_q == PBT_TURN) begin
			ack_prev_q <= req_tgl_q;
		end
	end

	always_ff @(posedge bus_clk) begin
		if (bus_rst) begin
			rdata_q <= '0;
		end else if (!ack_seen_q && ack_tgl_sync == req_tgl_q && req_tgl_q != ack_prev_q) begin
			rdata_q <= rdata_core_q;
		end
	end

	// target handshakes, driven only while claimed
	always_comb begin
		devsel_oe = (st_q == PBT_DATA) || (st_q == PBT_TURN);
		trdy_oe = devsel_oe;
		stop_oe = devsel_oe;
		devsel_n_out = !(st_q == PBT_DATA);
		trdy_n_out = !(st_q == PBT_DATA && ack_seen_q);
		// single-phase target: ask to end as soon as data moves
		stop_n_out = !(st_q == PBT_DATA && ack_seen_q && !frame_n);
	end

	always_comb begin
		ad_oe = (st_q == PBT_DATA) && !wr_q;
		ad_out = rdata_q;
	end

	// ------------------------------------------------------------
	// parity
	// ------------------------------------------------------------
	// parity one clock after our data phase; checking host parity likewise
	always_ff @(posedge bus_clk) begin
		if (bus_rst) begin
			par_pend_q <= 1'b0;
			par_out <= 1'b0;
			par_chk_q <= 1'b0;
			chk_bits_q <= '0;
			par_err <= 1'b0;
		end else begin
			par_pend_q <= ad_oe;
			par_out <= ^{ad_out, cbe_in};
			par_chk_q <= (st_q == PBT_IDLE && !frame_n && frame_q) || (wr_q && data_done);
			chk_bits_q <= {ad_in, cbe_in};
			par_err <= par_chk_q && ((^chk_bits_q) != par_in);
		end
	end
	assign par_oe = par_pend_q;

	// ------------------------------------------------------------
	// shared pins, interrupt
	// ------------------------------------------------------------
	always_comb begin
		cfg_sel_oe = !bus_enable && gpio_oe[2];
		cfg_sel_out = gpio_out[2];
		cbe_hi_oe = lane_hi_enable ? 2'b00 : gpio_oe[1:0];
		cbe_hi_out = gpio_out[1:0];
		interrupt_request_out_n = 1'b0;
		irq_oe = irq_req;
	end

	logic [2:0] gpio_raw;
	assign gpio_raw = {cfg_sel_in, cbe_in[3:2]};
	pbt_sync #(.WIDTH(3)) u_gpio_sync (
		.clk(core_clk),
		.rst(rst),
		.din(gpio_raw),
		.dout(gpio_in)
	);

	// ------------------------------------------------------------
	// core clock domain
	// ------------------------------------------------------------
	logic req_tgl_sync;
	logic req_seen_q;
	logic ack_tgl_q;
	logic busy_q;

	pbt_sync #(.WIDTH(1)) u_req_sync (
		.clk(core_clk),
		.rst(rst),
		.din(req_tgl_q),
		.dout(req_tgl_sync)
	);
	pbt_sync #(.WIDTH(1)) u_ack_sync (
		.clk(bus_clk),
		.rst(bus_rst),
		.din(ack_tgl_q),
		.dout(ack_tgl_sync)
	);

	// request fields are held stable by the bus side until acknowledged
	always_ff @(posedge core_clk) begin
		if (rst) begin
			req_seen_q <= 1'b0;
			busy_q <= 1'b0;
			req_valid <= 1'b0;
			req_write <= 1'b0;
			req_cfg <= 1'b0;
			req_addr <= '0;
			req_wdata <= '0;
			req_be <= '0;
			ack_tgl_q <= 1'b0;
			rdata_core_q <= '0;
		end else begin
			req_valid <= 1'b0;
			if (!busy_q && req_tgl_sync != req_seen_q) begin
				req_seen_q <= req_tgl_sync;
				busy_q <= 1'b1;
				req_valid <= 1'b1;
				req_write <= wr_q;
				req_cfg <= (kind_q == PBT_KIND_CFG);
				req_addr <= addr_q;
				req_wdata <= wdata_q;
				req_be <= ~be_q;
			end else if (busy_q && rsp_valid) begin
				busy_q <= 1'b0;
				rdata_core_q <= rsp_rdata;
				ack_tgl_q <= req_seen_q;
			end
		end
	end
endmodule // pbt_target

// file: pbt_defs.svh
// Purpose: constants for the bus target port
// Assumes: 32-bit bus, bus clock up to 33 MHz
// Notes: package pbt_pkg holds the types
`ifndef PBT_DEFS_SVH
`define PBT_DEFS_SVH

`define PBT_BUS_MHZ_MAX 33
`define PBT_CMD_MEM_RD 4'h6
`define PBT_CMD_MEM_WR 4'h7
`define PBT_CMD_CFG_RD 4'ha
`define PBT_CMD_CFG_WR 4'hb
`define PBT_BASE_BITS 8
`define PBT_BASE_RST 8'h00

`endif

// file: pbt_pkg.sv
// Purpose: types for the bus target port
// Assumes: nothing
// Notes: constants live in pbt_defs.svh
package pbt_pkg;
	typedef enum logic [2:0] {
		PBT_IDLE,
		PBT_CLAIM,
		PBT_DATA,
		PBT_TURN,
		PBT_BUSY
	} pbt_state_t;
	typedef enum logic [1:0] {
		PBT_KIND_MEM,
		PBT_KIND_CFG,
		PBT_KIND_NONE
	} pbt_kind_t;
endpackage

// file: pbt_sync.sv
// Purpose: two-stage level synchroniser, one per bit
// Assumes: destination clock free running
// Notes: first stage is read only by the second
module pbt_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule // pbt_sync

// file: pbt_target_monitor.sv
// Purpose: bus-side checks for the target port
// Assumes: bus_clk domain, mem_base held steady
// Notes: bound to pbt_target from tb
module pbt_target_monitor (
	input wire logic bus_clk,
	input wire logic bus_rst,
	input wire logic frame_n,
	input wire logic [31:0] ad_in,
	input wire logic [3:0] cbe_in,
	input wire logic cfg_sel_in,
	input wire logic [7:0] mem_base,
	input wire logic [31:0] ad_out,
	input wire logic ad_oe,
	input wire logic par_out,
	input wire logic par_oe,
	input wire logic devsel_n_out,
	input wire logic devsel_oe,
	input wire logic trdy_n_out,
	input wire logic trdy_oe,
	input wire logic stop_oe,
	input wire logic stop_n_out,
	input wire logic cfg_sel_oe,
	input wire logic interrupt_request_out_n,
	input wire logic irq_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge bus_clk);
	endclocking
	default disable iff (bus_rst);
	sequence s_mem_hit;
		$fell(frame_n) && cbe_in[3:1] == 3'h3 && ad_in[31:24] == mem_base;
	endsequence
	sequence s_claim;
		##[1:2] devsel_oe && !devsel_n_out;
	endsequence
	// three quiet edges cover claim plus first data phase
	sequence s_quiet;
		##1 !devsel_oe [*3];
	endsequence
	a_mem_claim:
	assert property (s_mem_hit |-> s_claim) else $error("memory hit not claimed");
	a_cmd_refused:
	assert property ($fell(frame_n) && !(cbe_in[3:1] inside {3'h3, 3'h5}) |-> s_quiet)
		else $error("unknown command claimed");
	a_cfg_select:
	assert property ($fell(frame_n) && cbe_in[3:1] == 3'h5 && !cfg_sel_in |-> s_quiet)
		else $error("config cycle claimed without select");
	a_par_even:
	assert property (ad_oe |=> par_oe && par_out == ^{$past(ad_out), $past(cbe_in)})
		else $error("read parity wrong or late");
	a_par_reads_only:
	assert property (par_oe |-> $past(ad_oe)) else $error("parity driven outside a read");
	a_idle_quiet:
	assert property (!devsel_oe |-> !(trdy_oe || stop_oe || ad_oe))
		else $error("bus driven while unclaimed");
	a_trdy_claimed:
	assert property (trdy_oe && !trdy_n_out |-> devsel_oe && !devsel_n_out)
		else $error("target ready without select");
	a_stop_claimed:
	assert property (stop_oe && !stop_n_out |-> devsel_oe && !devsel_n_out && !trdy_n_out)
		else $error("stop without a claimed data phase");
	a_irq_drain:
	assert property (irq_oe |-> !interrupt_request_out_n) else $error("irq drives high");
	a_alt_io_idle:
	assert property (cfg_sel_oe |-> !devsel_oe) else $error("claim while pin is io");
endmodule // pbt_target_monitor

// file: pbt_host_model.sv
// Purpose: initiator on the bus side of the target port
// Assumes: single data phase per access
// Notes: released lines show the inverse of their last value
module pbt_host_model (
	input wire logic bus_clk,
	output logic frame_n,
	output logic irdy_n,
	output logic [31:0] ad_in,
	output logic [3:0] cbe_in,
	output logic cfg_sel_in,
	output logic par_in,
	input wire logic [31:0] ad_out,
	input wire logic ad_oe,
	input wire logic [1:0] cbe_hi_out,
	input wire logic [1:0] cbe_hi_oe,
	input wire logic cfg_sel_out,
	input wire logic cfg_sel_oe,
	input wire logic trdy_n_out,
	input wire logic trdy_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] ad_h = 32'h0;
	logic [3:0] cbe_h = 4'h0;
	logic sel_h = 1'b0;
	// wire level: device drivers win over the released host side
	assign ad_in = ad_oe ? ad_out : ad_h;
	assign cbe_in = {cbe_hi_oe[1] ? cbe_hi_out[1] : cbe_h[3],
		cbe_hi_oe[0] ? cbe_hi_out[0] : cbe_h[2], cbe_h[1:0]};
	assign cfg_sel_in = cfg_sel_oe ? cfg_sel_out : sel_h;
	initial begin
		frame_n = 1'b1;
		irdy_n = 1'b1;
		par_in = 1'b0;
	end
	task automatic xfer(input logic [3:0] cmd, input logic sel, input logic [31:0] a,
		input logic [31:0] wd, input logic [3:0] be, output logic [31:0] rd, output logic ok);
		ok = 1'b0;
		rd = 32'h0;
		@(negedge bus_clk);
		frame_n = 1'b0;
		ad_h = a;
		cbe_h = cmd;
		sel_h = sel;
		@(negedge bus_clk);
		frame_n = 1'b1;
		irdy_n = 1'b0;
		ad_h = cmd[0] ? wd : ~a;
		cbe_h = ~be;
		sel_h = ~sel;
		par_in = ^{a, cmd};
		for (int n = 0; n < 40 && !ok; n++) begin
			@(posedge bus_clk);
			if (trdy_oe === 1'b1 && trdy_n_out === 1'b0) begin
				ok = 1'b1;
				rd = ad_in;
			end else begin
				@(negedge bus_clk);
				if (cmd[0]) par_in = ^{ad_h, cbe_h};
			end
		end
		@(negedge bus_clk);
		irdy_n = 1'b1;
		// write parity must stand one clock past the last data phase
		par_in = cmd[0] ? ^{ad_h, cbe_h} : ~par_in;
		ad_h = ~ad_h;
		cbe_h = ~cbe_h;
	endtask
endmodule // pbt_host_model

// file: tb.sv
// Purpose: self-checking bench for pbt_target
// Assumes: core user answers every request at once
// Notes: bus clock 6 ns, core clock 4 ns
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MB = 8'ha5;
	localparam logic [31:0] RD = 32'h5a3c_96e1;
	localparam logic [31:0] K = 32'h0f0f_c3c3;
	logic core_clk = 0, bus_clk = 0, rst = 1, bus_rst = 1;
	logic frame_n, irdy_n, cfg_sel_in, par_in, ad_oe, cfg_sel_out, cfg_sel_oe, par_out, par_oe;
	logic devsel_n_out, devsel_oe, trdy_n_out, trdy_oe, stop_n_out, stop_oe, irq_oe;
	logic interrupt_request_out_n, bus_enable, lane_hi_enable, irq_req, rsp_valid;
	logic req_valid, req_write, req_cfg;
	logic [31:0] ad_in, ad_out, req_wdata, rsp_rdata;
	logic [3:0] cbe_in, req_be;
	logic [1:0] cbe_hi_out, cbe_hi_oe;
	logic [2:0] gpio_out, gpio_oe, gpio_in;
	logic [7:0] mem_base;
	logic [29:0] req_addr;
	logic [67:0] cap;
	logic par_err;
	int bad_count = 0, check_count = 0, cyc = 0, par_hits = 0;
	always #2 core_clk = ~core_clk;
	always #3 bus_clk = ~bus_clk;
	pbt_target dut_u (.core_clk, .rst, .bus_clk, .bus_rst, .frame_n, .irdy_n, .ad_in, .ad_out,
		.ad_oe, .cbe_in, .cbe_hi_out, .cbe_hi_oe, .cfg_sel_in, .cfg_sel_out, .cfg_sel_oe,
		.par_in, .par_out, .par_oe, .devsel_n_out, .devsel_oe, .trdy_n_out, .trdy_oe,
		.stop_n_out, .stop_oe, .interrupt_request_out_n, .irq_oe, .bus_enable, .lane_hi_enable,
		.gpio_out, .gpio_oe, .gpio_in, .irq_req, .mem_base, .req_valid, .req_write, .req_cfg,
		.req_addr, .req_wdata, .req_be, .rsp_valid, .rsp_rdata, .par_err);
	always @(posedge bus_clk) if (!bus_rst && par_err !== 1'b0) par_hits++;
	pbt_host_model host_u (.bus_clk, .frame_n, .irdy_n, .ad_in, .cbe_in, .cfg_sel_in, .par_in,
		.ad_out, .ad_oe, .cbe_hi_out, .cbe_hi_oe, .cfg_sel_out, .cfg_sel_oe, .trdy_n_out, .trdy_oe);
	// user side answers the request on the falling edge after it appears
	always @(negedge core_clk) begin
		rsp_valid <= req_valid;
		if (req_valid) cap <= {req_cfg, req_write, req_be, req_addr, req_wdata};
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end
	task automatic chk(input logic [67:0] g, input logic [67:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic acc(input logic [3:0] cmd, input logic sel, input logic [31:0] a,
		input logic claim);
		logic [31:0] rd;
		logic ok;
		cap = '1;
		host_u.xfer(cmd, sel, a, a ^ K, 4'h9, rd, ok);
		chk(68'(ok), 68'(claim));
		repeat (2) @(negedge bus_clk);
		chk(68'(par_hits), 68'(0));
		if (claim) begin
			chk(68'(cap[67:32]), 68'({cmd[3], cmd[0], 4'h9, a[31:2]}));
			chk(68'(cmd[0] ? cap[31:0] : rd), 68'(cmd[0] ? a ^ K : RD));
		end
	endtask
	task automatic t_mem();
		acc(4'h7, 1'b0, {MB, 24'h12_3457}, 1'b1);
		acc(4'h6, 1'b0, {MB, 24'hff_fff8}, 1'b1);
		acc(4'h7, 1'b0, {~MB, 24'h00_0010}, 1'b0);
	endtask
	task automatic t_cfg();
		acc(4'hb, 1'b1, 32'h0000_0104, 1'b1);
		acc(4'ha, 1'b1, 32'h0000_0010, 1'b1);
		acc(4'ha, 1'b0, 32'h0000_0010, 1'b0);
	endtask
	task automatic t_cmds();
		for (int c = 0; c < 16; c++)
			if (!(c inside {6, 7, 10, 11})) acc(4'(c), 1'b1, {MB, 24'h00_0040}, 1'b0);
	endtask
	task automatic t_alt();
		bus_enable = 1'b0;
		lane_hi_enable = 1'b0;
		gpio_out = 3'b101;
		gpio_oe = 3'b111;
		repeat (20) @(negedge core_clk);
		chk(68'({cfg_sel_oe, cfg_sel_out, cbe_hi_oe, cbe_hi_out}), 68'(6'h3d));
		chk(68'(gpio_in), 68'(3'b101));
		bus_enable = 1'b1;
		lane_hi_enable = 1'b1;
		repeat (20) @(negedge core_clk);
		chk(68'({cfg_sel_oe, cbe_hi_oe}), 68'(0));
	endtask
	task automatic t_irq();
		irq_req = 1'b1;
		repeat (8) @(negedge core_clk);
		chk(68'({irq_oe, interrupt_request_out_n}), 68'(2'b10));
		irq_req = 1'b0;
		repeat (8) @(negedge core_clk);
		chk(68'(irq_oe), 68'(0));
	endtask
	initial begin
		bus_enable = 1'b1;
		lane_hi_enable = 1'b1;
		irq_req = 1'b0;
		gpio_out = 3'h0;
		gpio_oe = 3'h0;
		mem_base = MB;
		rsp_valid = 1'b0;
		rsp_rdata = RD;
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		bus_rst = 1'b0;
		repeat (4) @(negedge bus_clk);
		t_mem();
		t_cfg();
		t_cmds();
		t_alt();
		t_irq();
		close_out();
	end
endmodule // tb
bind pbt_target pbt_target_monitor mon_u (.bus_clk, .bus_rst, .frame_n, .ad_in, .cbe_in,
	.cfg_sel_in, .mem_base, .ad_out, .ad_oe, .par_out, .par_oe, .devsel_n_out, .devsel_oe,
	.trdy_n_out, .trdy_oe, .stop_oe, .stop_n_out, .cfg_sel_oe, .interrupt_request_out_n, .irq_oe);
